/* shared/mac_cfg_pkg.sv */
package mac_cfg_pkg;

    // Register map, byte addresses
    localparam logic [7:0] CTRL_OFFSET = 8'h38;
    localparam int         MAP_ADDR_W  = 8;

    // Field positions inside the control word
    localparam int GAP_DIR_BIT = 23;
    localparam int GAP_CNT_LSB = 20;
    localparam int TX_DESC_LSB = 16;
    localparam int RX_DESC_LSB = 12;
    localparam int TX_BST_LSB  = 10;
    localparam int RX_BST_LSB  = 8;
    localparam int GAP_CNT_W   = 3;
    localparam int DESC_W      = 4;
    localparam int BST_W       = 2;

    // Byte lanes holding the fields
    localparam int LANE_GAP_TXD = 2;
    localparam int LANE_RXD_BST = 1;

    // Reset values
    localparam logic                 GAP_DIR_RST = 1'b0;
    localparam logic [GAP_CNT_W-1:0] GAP_CNT_RST = 3'h0;
    localparam logic [DESC_W-1:0]    DESC_RST    = 4'h2;
    localparam logic [BST_W-1:0]     BST_RST     = 2'h3;

    // Units
    localparam int BURST_BASE_BYTES = 64;
    localparam int DESC_UNIT_BYTES  = 8;
    localparam int BURST_BYTES_W    = 10;
    localparam int DESC_BYTES_W     = 7;
    localparam int GAP_CYC_W        = 7;

    // Timing: transmit clock periods against the 40 ns core clock
    localparam int CORE_PERIOD_NS   = 40;
    localparam int TXCLK_100M_NS    = 40;
    localparam int TXCLK_10M_NS     = 400;
    localparam int TXCLK_100M_CYC_I = (TXCLK_100M_NS / CORE_PERIOD_NS) < 1 ? 1
                                    : (TXCLK_100M_NS / CORE_PERIOD_NS);
    localparam int TXCLK_10M_CYC_I  = (TXCLK_10M_NS / CORE_PERIOD_NS) < 1 ? 1
                                    : (TXCLK_10M_NS / CORE_PERIOD_NS);
    localparam logic [3:0] TXCLK_100M_CYC = 4'(TXCLK_100M_CYC_I);
    localparam logic [3:0] TXCLK_10M_CYC  = 4'(TXCLK_10M_CYC_I);

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

/* rtl/pin_sync3.sv */
`timescale 1ns/1ps
// Three-stage pin synchroniser; the level only moves once stages two and three agree
module pin_sync3
(
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic pin,
    output logic      level
);

    logic stage1;
    logic stage2;
    logic stage3;
    logic next_level;

    // Stage one feeds stage two only, to keep metastability contained
    always_comb
    begin
        next_level = level;
        if (stage2 == stage3)
        begin
            next_level = stage3;
        end
    end

    // Register the chain and the filtered level
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level  <= 1'b0;
        end
        else
        begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end

endmodule

/* rtl/mac_burst_gap_cfg.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Direction bit set lengthens gap, reset zero
// - Three-bit count adjusts gap in transmit clocks
// - Transmit descriptor length in 8-byte units, never zero
// - Receive descriptor length in 8-byte units, never zero
// - Transmit burst cap 64 to 512 bytes
// - Receive burst cap 64 to 512 bytes
module mac_burst_gap_cfg
    import mac_cfg_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
)
(
    input  wire logic                              core_clk,
    input  wire logic                              reset,
    input  wire logic [ADDR_WIDTH-1:0]             s_axi_awaddr,
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [31:0]                       s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    output logic [1:0]                             s_axi_bresp,
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [ADDR_WIDTH-1:0]             s_axi_araddr,
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    output logic [31:0]                            s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    input  wire logic                              speed_10m,
    output logic                                   gap_direction_up,
    output logic [mac_cfg_pkg::GAP_CNT_W-1:0]      gap_adjust_count,
    output logic [mac_cfg_pkg::GAP_CYC_W-1:0]      gap_adjust_core_cycles,
    output logic [mac_cfg_pkg::DESC_W-1:0]         tx_descriptor_length,
    output logic [mac_cfg_pkg::DESC_W-1:0]         rx_descriptor_length,
    output logic [mac_cfg_pkg::DESC_BYTES_W-1:0]   tx_descriptor_bytes,
    output logic [mac_cfg_pkg::DESC_BYTES_W-1:0]   rx_descriptor_bytes,
    output logic [mac_cfg_pkg::BST_W-1:0]          tx_burst_limit,
    output logic [mac_cfg_pkg::BST_W-1:0]          rx_burst_limit,
    output logic [mac_cfg_pkg::BURST_BYTES_W-1:0]  tx_burst_bytes,
    output logic [mac_cfg_pkg::BURST_BYTES_W-1:0]  rx_burst_bytes
);

    import mac_cfg_pkg::*;

    // Checks sample on the core clock and rest while reset is high
    default clocking core_cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    // Decoder needs the full low byte of the map; refused at elaboration
    if (ADDR_WIDTH < MAP_ADDR_W || ADDR_WIDTH > 32)
    begin
        $error("ADDR_WIDTH must lie between 8 and 32");
    end

    // True when the word address hits the control register
    function automatic logic hits_ctrl(input logic [ADDR_WIDTH-1:0] addr);
        logic [31:0] wide;
        wide = 32'(addr);
        return (wide[31:2] == 30'(CTRL_OFFSET[7:2]));
    endfunction

    // Burst code to byte cap; 64 bytes doubled per code step, so code 3 gives 512
    function automatic logic [BURST_BYTES_W-1:0] burst_bytes(input logic [BST_W-1:0] code);
        logic [BURST_BYTES_W-1:0] base;
        base = BURST_BYTES_W'(BURST_BASE_BYTES);
        return base << code;
    endfunction

    // Descriptor length to bytes
    function automatic logic [DESC_BYTES_W-1:0] desc_bytes(input logic [DESC_W-1:0] len);
        return DESC_BYTES_W'(len) * DESC_BYTES_W'(DESC_UNIT_BYTES);
    endfunction

    logic                 speed_10m_level;
    logic                 aw_held;
    logic                 w_held;
    logic [ADDR_WIDTH-1:0] aw_addr;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 write_go;
    logic [31:0]          ctrl_word;
    logic                   next_awready;
    logic                   next_wready;
    logic                   next_aw_held;
    logic                   next_w_held;
    logic [ADDR_WIDTH-1:0]  next_aw_addr;
    logic [31:0]            next_w_data;
    logic [3:0]             next_w_strb;
    logic                   next_bvalid;
    logic [1:0]             next_bresp;
    logic                   next_arready;
    logic                   next_rvalid;
    logic [31:0]            next_rdata;
    logic [1:0]             next_rresp;
    logic                   next_gap_dir;
    logic [GAP_CNT_W-1:0]   next_gap_cnt;
    logic [DESC_W-1:0]      next_txd;
    logic [DESC_W-1:0]      next_rxd;
    logic [BST_W-1:0]       next_txb;
    logic [BST_W-1:0]       next_rxb;
    logic [GAP_CYC_W-1:0]   next_gap_cycles;

    // Link speed strap is a pin from outside the core domain
    pin_sync3 u_speed_sync
    (
        .core_clk (core_clk),
        .reset    (reset),
        .pin      (speed_10m),
        .level    (speed_10m_level)
    );

    // Readback image; reserved top byte and the unowned low byte read zero
    always_comb
    begin
        ctrl_word = 32'h0;
        ctrl_word[GAP_DIR_BIT] = gap_direction_up;
        ctrl_word[GAP_CNT_LSB +: GAP_CNT_W] = gap_adjust_count;
        ctrl_word[TX_DESC_LSB +: DESC_W] = tx_descriptor_length;
        ctrl_word[RX_DESC_LSB +: DESC_W] = rx_descriptor_length;
        ctrl_word[TX_BST_LSB +: BST_W] = tx_burst_limit;
        ctrl_word[RX_BST_LSB +: BST_W] = rx_burst_limit;
    end

    assign write_go = aw_held && w_held && !s_axi_bvalid;
    // Write channels: address and data taken in either order, answer after both
    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
        if (write_go)
        begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = hits_ctrl(aw_addr) ? RESP_OKAY : RESP_DECERR;
        end
        // One write at a time: no new beat until the response is gone
        next_awready = !next_aw_held && !next_bvalid;
        next_wready  = !next_w_held && !next_bvalid;
    end

    // Field updates; a zero descriptor length is illegal and is dropped
    always_comb
    begin
        next_gap_dir = gap_direction_up;
        next_gap_cnt = gap_adjust_count;
        next_txd     = tx_descriptor_length;
        next_rxd     = rx_descriptor_length;
        next_txb     = tx_burst_limit;
        next_rxb     = rx_burst_limit;
        if (write_go && hits_ctrl(aw_addr))
        begin
            if (w_strb[LANE_GAP_TXD])
            begin
                next_gap_dir = w_data[GAP_DIR_BIT];
                next_gap_cnt = w_data[GAP_CNT_LSB +: GAP_CNT_W];
                if (w_data[TX_DESC_LSB +: DESC_W] != 4'h0)
                begin
                    next_txd = w_data[TX_DESC_LSB +: DESC_W];
                end
            end
            if (w_strb[LANE_RXD_BST])
            begin
                if (w_data[RX_DESC_LSB +: DESC_W] != 4'h0)
                begin
                    next_rxd = w_data[RX_DESC_LSB +: DESC_W];
                end
                next_txb = w_data[TX_BST_LSB +: BST_W];
                next_rxb = w_data[RX_BST_LSB +: BST_W];
            end
        end
    end

    // Gap step in core cycles: one transmit clock is 1 or 10 core cycles
    always_comb
    begin
        next_gap_cycles = GAP_CYC_W'(next_gap_cnt)
                        * GAP_CYC_W'(speed_10m_level ? TXCLK_10M_CYC
                                                     : TXCLK_100M_CYC);
    end

    // Read channel: answer one cycle after the address is taken
    always_comb
    begin
        next_rvalid = s_axi_rvalid;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rdata  = hits_ctrl(s_axi_araddr) ? ctrl_word : 32'h0;
            next_rresp  = hits_ctrl(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
        end
        next_arready = !next_rvalid;
    end

    // Bus state registers
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= 32'h0;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            aw_addr       <= next_aw_addr;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    // Control fields and their decoded forms, registered together so they never skew
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            gap_direction_up       <= GAP_DIR_RST;
            gap_adjust_count       <= GAP_CNT_RST;
            gap_adjust_core_cycles <= '0;
            tx_descriptor_length   <= DESC_RST;
            rx_descriptor_length   <= DESC_RST;
            tx_descriptor_bytes    <= DESC_BYTES_W'(16);
            rx_descriptor_bytes    <= DESC_BYTES_W'(16);
            tx_burst_limit         <= BST_RST;
            rx_burst_limit         <= BST_RST;
            tx_burst_bytes         <= BURST_BYTES_W'(512);
            rx_burst_bytes         <= BURST_BYTES_W'(512);
        end
        else
        begin
            gap_direction_up       <= next_gap_dir;
            gap_adjust_count       <= next_gap_cnt;
            gap_adjust_core_cycles <= next_gap_cycles;
            tx_descriptor_length   <= next_txd;
            rx_descriptor_length   <= next_rxd;
            tx_descriptor_bytes    <= desc_bytes(next_txd);
            rx_descriptor_bytes    <= desc_bytes(next_rxd);
            tx_burst_limit         <= next_txb;
            rx_burst_limit         <= next_rxb;
            tx_burst_bytes         <= burst_bytes(next_txb);
            rx_burst_bytes         <= burst_bytes(next_rxb);
        end
    end

    // Checks; the gap step lags a speed change by one edge, so only a settled speed is judged
    property p_gap_dir_write;
        (write_go && hits_ctrl(aw_addr) && w_strb[2])
            |=> (gap_direction_up == $past(w_data[23]));
    endproperty
    a_gap_dir_write: assert property (p_gap_dir_write)
        else $error("gap direction not taken from write");
    property p_gap_cycles;
        $stable(speed_10m_level) |-> (gap_adjust_core_cycles == (speed_10m_level
            ? 7'(gap_adjust_count) * 7'd10 : 7'(gap_adjust_count)));
    endproperty
    a_gap_cycles: assert property (p_gap_cycles)
        else $error("gap step in core cycles is wrong");
    property p_txd_zero_kept;
        (write_go && w_strb[2] && w_data[19:16] == 4'h0)
            |=> $stable(tx_descriptor_length) && tx_descriptor_length != 4'h0;
    endproperty
    a_txd_zero_kept: assert property (p_txd_zero_kept)
        else $error("transmit descriptor length took zero");
    property p_rxd_bytes;
        rx_descriptor_length != 4'h0
            && rx_descriptor_bytes == {rx_descriptor_length, 3'b000};
    endproperty
    a_rxd_bytes: assert property (p_rxd_bytes)
        else $error("receive descriptor size inconsistent");
    property p_tx_burst;
        (tx_burst_limit == 2'h0) |-> (tx_burst_bytes == 10'd64);
    endproperty
    a_tx_burst: assert property (p_tx_burst)
        else $error("transmit burst cap for code 0 wrong");
    property p_rx_burst;
        (rx_burst_limit == 2'h2) |-> (rx_burst_bytes == 10'd256);
    endproperty
    a_rx_burst: assert property (p_rx_burst)
        else $error("receive burst cap for code 2 wrong");
    property p_rx_burst_top;
        ((s_axi_rvalid && s_axi_rresp == 2'h0) |-> (s_axi_rdata[31:24] == 8'h00))
            and ((rx_burst_limit == 2'h3) |-> (rx_burst_bytes == 10'd512));
    endproperty
    a_rx_burst_top: assert property (p_rx_burst_top)
        else $error("reserved byte or receive cap 512 wrong");

endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import mac_cfg_pkg::*;

    logic        core_clk;
    logic        reset;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic        speed_10m;
    logic        gap_direction_up;
    logic [2:0]  gap_adjust_count;
    logic [6:0]  gap_adjust_core_cycles;
    logic [3:0]  tx_descriptor_length;
    logic [3:0]  rx_descriptor_length;
    logic [6:0]  tx_descriptor_bytes;
    logic [6:0]  rx_descriptor_bytes;
    logic [1:0]  tx_burst_limit;
    logic [1:0]  rx_burst_limit;
    logic [9:0]  tx_burst_bytes;
    logic [9:0]  rx_burst_bytes;
    logic [1:0]  resp;
    logic [31:0] rdata;
    int          num_errors;
    int          compares;

    mac_burst_gap_cfg DUT
    (
        .core_clk               (core_clk),
        .reset                  (reset),
        .s_axi_awaddr           (s_axi_awaddr),
        .s_axi_awvalid          (s_axi_awvalid),
        .s_axi_awready          (s_axi_awready),
        .s_axi_wdata            (s_axi_wdata),
        .s_axi_wstrb            (s_axi_wstrb),
        .s_axi_wvalid           (s_axi_wvalid),
        .s_axi_wready           (s_axi_wready),
        .s_axi_bresp            (s_axi_bresp),
        .s_axi_bvalid           (s_axi_bvalid),
        .s_axi_bready           (s_axi_bready),
        .s_axi_araddr           (s_axi_araddr),
        .s_axi_arvalid          (s_axi_arvalid),
        .s_axi_arready          (s_axi_arready),
        .s_axi_rdata            (s_axi_rdata),
        .s_axi_rresp            (s_axi_rresp),
        .s_axi_rvalid           (s_axi_rvalid),
        .s_axi_rready           (s_axi_rready),
        .speed_10m              (speed_10m),
        .gap_direction_up       (gap_direction_up),
        .gap_adjust_count       (gap_adjust_count),
        .gap_adjust_core_cycles (gap_adjust_core_cycles),
        .tx_descriptor_length   (tx_descriptor_length),
        .rx_descriptor_length   (rx_descriptor_length),
        .tx_descriptor_bytes    (tx_descriptor_bytes),
        .rx_descriptor_bytes    (rx_descriptor_bytes),
        .tx_burst_limit         (tx_burst_limit),
        .rx_burst_limit         (rx_burst_limit),
        .tx_burst_bytes         (tx_burst_bytes),
        .rx_burst_bytes         (rx_burst_bytes)
    );

    // 25 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Compare and count; unknowns never match
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Control word from field values; top and low bytes left clear
    function automatic logic [31:0] word(input logic dir, input logic [2:0] cnt,
        input logic [3:0] txd, input logic [3:0] rxd, input logic [1:0] txb,
        input logic [1:0] rxb);
        return {8'h00, dir, cnt, txd, rxd, txb, rxb, 8'h00};
    endfunction

    // One write; each channel dropped on its own handshake, bready held until bvalid
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        bit done;
        done = 1'b0;
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        // Waits for the answer however long; only the watchdog ends a hang
        while (!done)
        begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
            begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
        // One idle edge, so a following call never drives bready twice in a step
        @(posedge core_clk);
        check("write answer", 32'(resp == RESP_OKAY || resp == RESP_DECERR), 32'h1);
    endtask

    // One read; rready held until rvalid
    task automatic axi_read(input logic [7:0] a);
        bit done;
        done = 1'b0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!done)
        begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
            begin
                rdata = s_axi_rdata;
                resp  = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
        @(posedge core_clk);
        check("read answer", 32'(resp == RESP_OKAY || resp == RESP_DECERR), 32'h1);
    endtask

    // Values straight after reset
    task automatic test_reset();
        axi_read(CTRL_OFFSET);
        check("reset word", rdata, word(1'b0, 3'h0, 4'h2, 4'h2, 2'h3, 2'h3));
        check("reset dir", 32'(gap_direction_up), 32'h0);
        check("reset count", 32'(gap_adjust_count), 32'h0);
        check("reset tx desc bytes", 32'(tx_descriptor_bytes), 32'h10);
        check("reset rx desc bytes", 32'(rx_descriptor_bytes), 32'h10);
        check("reset tx burst", 32'(tx_burst_bytes), 32'h200);
        check("reset rx burst", 32'(rx_burst_bytes), 32'h200);
        $display("test_reset done");
    endtask

    // Every burst code on both movers, opposite codes at once
    task automatic test_bursts();
        for (int c = 0; c < 4; c++)
        begin
            axi_write(CTRL_OFFSET, word(1'b0, 3'h0, 4'h2, 4'h2, 2'(c), 2'(3 - c)), 4'h6);
            check("tx burst bytes", 32'(tx_burst_bytes), 32'(64 << c));
            check("rx burst bytes", 32'(rx_burst_bytes), 32'(64 << (3 - c)));
            check("tx burst code", 32'(tx_burst_limit), 32'(c));
            check("rx burst code", 32'(rx_burst_limit), 32'(3 - c));
            axi_read(CTRL_OFFSET);
            check("burst word", rdata, word(1'b0, 3'h0, 4'h2, 4'h2, 2'(c), 2'(3 - c)));
        end
        $display("test_bursts done");
    endtask

    // Gap direction and count, and the gap step at both link speeds
    task automatic test_gap();
        axi_write(CTRL_OFFSET, word(1'b1, 3'h7, 4'h2, 4'h2, 2'h3, 2'h3), 4'h6);
        check("gap dir up", 32'(gap_direction_up), 32'h1);
        check("gap count 7", 32'(gap_adjust_count), 32'h7);
        check("gap cycles 100M", 32'(gap_adjust_core_cycles), 32'h7);
        axi_write(CTRL_OFFSET, word(1'b0, 3'h5, 4'h2, 4'h2, 2'h3, 2'h3), 4'h6);
        check("gap dir down", 32'(gap_direction_up), 32'h0);
        check("gap count 5", 32'(gap_adjust_count), 32'h5);
        // Pin passes a synchroniser, so give it time to settle
        speed_10m <= 1'b1;
        repeat (8) @(posedge core_clk);
        axi_write(CTRL_OFFSET, word(1'b1, 3'h3, 4'h2, 4'h2, 2'h3, 2'h3), 4'h6);
        check("gap cycles 10M", 32'(gap_adjust_core_cycles), 32'(3 * 10));
        speed_10m <= 1'b0;
        repeat (8) @(posedge core_clk);
        $display("test_gap done");
    endtask

    // Descriptor sizes, zero writes dropped, reserved bytes read zero
    task automatic test_desc();
        axi_write(CTRL_OFFSET, 32'hff0f1fff, 4'hf);
        check("tx desc bytes", 32'(tx_descriptor_bytes), 32'(15 * 8));
        check("rx desc bytes", 32'(rx_descriptor_bytes), 32'(1 * 8));
        axi_write(CTRL_OFFSET, word(1'b1, 3'h6, 4'h0, 4'h0, 2'h0, 2'h0), 4'hf);
        check("tx desc kept", 32'(tx_descriptor_length), 32'hf);
        check("rx desc kept", 32'(rx_descriptor_length), 32'h1);
        check("count beside zero", 32'(gap_adjust_count), 32'h6);
        check("burst beside zero", 32'(rx_burst_bytes), 32'h40);
        axi_read(CTRL_OFFSET);
        check("desc word", rdata, word(1'b1, 3'h6, 4'hf, 4'h1, 2'h0, 2'h0));
        $display("test_desc done");
    endtask

    // Single lane write, then accesses off the map
    task automatic test_lanes();
        axi_write(CTRL_OFFSET, 32'hffffffff, 4'h2);
        axi_read(CTRL_OFFSET);
        check("lane1 only", rdata, word(1'b1, 3'h6, 4'hf, 4'hf, 2'h3, 2'h3));
        axi_write(8'h3c, 32'h0, 4'hf);
        check("unmapped bresp", 32'(resp), 32'(RESP_DECERR));
        axi_read(8'h3c);
        check("unmapped rresp", 32'(resp), 32'(RESP_DECERR));
        check("unmapped rdata", rdata, 32'h0);
        axi_read(CTRL_OFFSET);
        check("word kept", rdata, word(1'b1, 3'h6, 4'hf, 4'hf, 2'h3, 2'h3));
        $display("test_lanes done");
    endtask

    // Counts, verdict and end of run
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        num_errors    = 0;
        compares      = 0;
        reset         = 1'b1;
        speed_10m     = 1'b0;
        s_axi_awaddr  = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h0;
        s_axi_wstrb   = 4'h0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        repeat (2) @(posedge core_clk);
        test_reset();
        test_bursts();
        test_gap();
        test_desc();
        test_lanes();
        results();
    end

    // Watchdog, far beyond the hundred or so cycles the tests need
    initial
    begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        $display("Watchdog expired");
        results();
    end
endmodule
